/* rtl/common_ctrl_pkg.sv */
// constants, types and field layout of the common control register group
// Function
// (RULE1) add-bus outputs of a channel drive only when both enables are set
// (RULE2) device add-bus enable at zero forces every add-bus output off
// (RULE3) any reset clears device add-bus and receive output enables
// (RULE4) receive and monitor outputs drive only when both output enables set
// (RULE5) device receive output enable at zero floats every receive output
// (RULE6) interrupt enable and tri-state control together decide the pin drive
// (RULE7) both set: pin driven, polarity given by processor mode
// (RULE8) tri-state control at zero floats the pin in its off state
// (RULE9) software keeps the two test selection bits at zero normally
// (RULE10) loopback control at zero gives normal channel operation
// (RULE11) loopback with AIS enable off sends received line data
// (RULE12) loopback with AIS enable on sends an alarm indication signal
// (RULE13) a set channel reset bit holds that channel in reset
// (RULE14) channel reset bits stay set until software writes zero
// (RULE15) writing one to device reset acts like the hardware reset
// (RULE16) device reset bit clears itself when the sequence is done
// (RULE17) software writes zero to reserved bits
package common_ctrl_pkg;

    // =========================================================
    // register offsets
    localparam logic [7:0] IRQ_OUT_EN_OFS  = 8'hC2;
    localparam logic [7:0] RSVD_C3_OFS     = 8'hC3;
    localparam logic [7:0] RSVD_C4_OFS     = 8'hC4;
    localparam logic [7:0] TEST_LBK_OFS    = 8'hC5;
    localparam logic [7:0] RSVD_C6_OFS     = 8'hC6;
    localparam logic [7:0] RESET_CTRL_OFS  = 8'hC7;

    // =========================================================
    // field positions
    localparam int DEV_RX_OE_BIT     = 0;
    localparam int DEV_ADD_EN_BIT    = 1;
    localparam int IRQ_EN_BIT        = 2;
    localparam int IRQ_TRI_BIT       = 3;
    localparam int LBK_AIS_BIT       = 0;
    localparam int TEST_LO_BIT       = 1;
    localparam int TEST_HI_BIT       = 2;
    localparam int DEV_RST_BIT       = 0;
    localparam int CHAN1_RST_BIT     = 1;
    localparam int CHAN3_RST_BIT     = 3;

    // =========================================================
    // reset values and widths
    localparam logic [3:0] IRQ_OUT_EN_RST = 4'h0;
    localparam logic [2:0] TEST_LBK_RST   = 3'h0;
    localparam logic [2:0] CHAN_RST_RST   = 3'h0;
    localparam int         NUM_CHAN       = 3;

    // =========================================================
    // timing
    localparam int CLK_PERIOD_NS    = 50;
    localparam int DEV_RST_SEQ_NS   = 400;
    localparam int DEV_RST_CYCLES   =
        (DEV_RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] DEV_RST_CNT_MAX = 4'(DEV_RST_CYCLES - 1);

    // =========================================================
    // types
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_BUSY = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [2:0] addbus_en;
        logic [2:0] rx_oe;
        logic [2:0] loopback;
    } chan_ctrl_t;

    typedef struct packed {
        logic [2:0] addbus_drive;
        logic [2:0] rx_drive;
        logic [2:0] loop_active;
        logic [2:0] ais_insert;
        logic [2:0] chan_reset;
    } chan_out_t;

endpackage

/* rtl/dev_reset_seq.sv */
// self-timed sequencer for the software device reset
`timescale 1ns/10ps
`default_nettype none
module dev_reset_seq (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic start,
    output logic      busy
);
    import common_ctrl_pkg::*;

    seq_state_t state_reg;
    seq_state_t state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // =========================================================
    // sequence
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            SEQ_IDLE: begin
                cnt_next = 4'h0;
                if (start) begin
                    state_next = SEQ_BUSY;
                end
            end
            SEQ_BUSY: begin
                cnt_next = cnt_reg + 4'h1;
                // (RULE16) ends after fixed count
                if (cnt_reg == DEV_RST_CNT_MAX) begin
                    state_next = SEQ_IDLE;
                    cnt_next   = 4'h0;
                end
            end
            default: begin
                state_next = SEQ_IDLE;
                cnt_next   = 4'h0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= SEQ_IDLE;
            cnt_reg   <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign busy = (state_reg == SEQ_BUSY);

endmodule
`default_nettype wire

/* rtl/common_device_control.sv */
// common device control registers and output gating
`timescale 1ns/10ps
`default_nettype none
module common_device_control (
    input  wire logic                        mclk,
    input  wire logic                        srst,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [7:0]                       reg_rdata,
    input  wire logic                        motorola_mode,
    input  wire logic                        irq_event,
    output logic                             irq_out,
    output logic                             irq_oe,
    input  wire common_ctrl_pkg::chan_ctrl_t chan_ctrl,
    output common_ctrl_pkg::chan_out_t       chan_out,
    output logic [1:0]                       test_sel,
    output logic                             device_reset
);
    import common_ctrl_pkg::*;

    // =========================================================
    // helpers
    function automatic logic [2:0] gate3(input logic dev,
                                         input logic [2:0] chan);
        gate3 = chan & {3{dev}};
    endfunction

    // =========================================================
    // pin synchroniser for the processor mode strap
    logic mode_meta_reg;
    logic mode_sync_reg;

    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_meta_reg <= 1'b0;
            mode_sync_reg <= 1'b0;
        end else begin
            mode_meta_reg <= motorola_mode;
            mode_sync_reg <= mode_meta_reg;
        end
    end

    // =========================================================
    // decode
    wire hit_irq_out = (reg_addr == IRQ_OUT_EN_OFS);
    wire hit_test    = (reg_addr == TEST_LBK_OFS);
    wire hit_reset   = (reg_addr == RESET_CTRL_OFS);

    logic seq_busy;
    // soft reset blocks writes so the cleared state cannot be undone midway
    wire  wr_ok      = reg_wr & ~seq_busy;
    // (RULE15) device reset bit starts sequence
    wire  seq_start  = wr_ok & hit_reset & reg_wdata[DEV_RST_BIT];
    wire  clear_all  = seq_busy;
    // (RULE15) add-bus, receive and interrupt outputs forced off for the whole soft reset
    // gating here keeps the first busy cycle clean, before registers clear
    wire  outs_live  = ~seq_busy;

    dev_reset_seq u_seq (
        .mclk  (mclk),
        .srst  (srst),
        .start (seq_start),
        .busy  (seq_busy)
    );

    // =========================================================
    // control registers
    logic [3:0] irq_out_en_reg;
    logic [2:0] test_lbk_reg;
    logic [2:0] chan_rst_reg;

    // (RULE3) hardware or device reset clears enables
    always_ff @(posedge mclk) begin
        if (srst || clear_all) begin
            irq_out_en_reg <= IRQ_OUT_EN_RST;
        end else if (wr_ok && hit_irq_out) begin
            // reserved bits are not stored and read as zero
            irq_out_en_reg <= reg_wdata[IRQ_TRI_BIT:DEV_RX_OE_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || clear_all) begin
            test_lbk_reg <= TEST_LBK_RST;
        end else if (wr_ok && hit_test) begin
            test_lbk_reg <= reg_wdata[TEST_HI_BIT:LBK_AIS_BIT];
        end
    end

    // (RULE14) chan_rst_reg held until written zero or cleared by a reset
    always_ff @(posedge mclk) begin
        if (srst || clear_all) begin
            chan_rst_reg <= CHAN_RST_RST;
        end else if (wr_ok && hit_reset) begin
            chan_rst_reg <= reg_wdata[CHAN3_RST_BIT:CHAN1_RST_BIT];
        end
    end

    wire dev_rx_oe  = irq_out_en_reg[DEV_RX_OE_BIT];
    wire dev_add_en = irq_out_en_reg[DEV_ADD_EN_BIT];
    wire irq_en     = irq_out_en_reg[IRQ_EN_BIT];
    wire irq_tri    = irq_out_en_reg[IRQ_TRI_BIT];
    wire lbk_ais    = test_lbk_reg[LBK_AIS_BIT];

    // =========================================================
    // read port
    wire [7:0] rd_irq   = {4'h0, irq_out_en_reg};
    wire [7:0] rd_test  = {5'h00, test_lbk_reg};
    wire [7:0] rd_reset = {4'h0, chan_rst_reg, seq_busy};
    wire [7:0] rd_mux   = hit_irq_out ? rd_irq :
                          hit_test    ? rd_test :
                          hit_reset   ? rd_reset : 8'h00;

    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // =========================================================
    // interrupt pin
    // (RULE6) enable and tri-state control combined
    wire irq_active = irq_event & irq_en & outs_live;
    // (RULE7) polarity follows processor mode
    wire irq_level  = irq_active ^ mode_sync_reg;
    // (RULE8) off state floats unless tri-state control and interrupt enable both set
    wire irq_drive  = irq_active | (irq_tri & irq_en & outs_live);

    // =========================================================
    // channel outputs
    // (RULE1) add bus needs both enables
    // (RULE2) device enable off forces all off
    wire [2:0] add_drive  = gate3(dev_add_en & outs_live,
                                  chan_ctrl.addbus_en);
    // (RULE4) receive outputs need both enables
    // (RULE5) device enable off floats all
    wire [2:0] rx_drive   = gate3(dev_rx_oe & outs_live, chan_ctrl.rx_oe);
    // (RULE10) no loopback means normal path
    // (RULE11) loopback carries received data
    wire [2:0] loop_act   = chan_ctrl.loopback;
    // (RULE12) loopback with AIS substitution
    wire [2:0] ais_ins    = gate3(lbk_ais, chan_ctrl.loopback);
    // (RULE13) channel held in reset
    wire [2:0] chan_rst   = chan_rst_reg | {3{seq_busy}};

    always_ff @(posedge mclk) begin
        if (srst) begin
            chan_out     <= '0;
            irq_out      <= 1'b0;
            irq_oe       <= 1'b0;
            device_reset <= 1'b0;
            test_sel     <= 2'b00;
        end else begin
            chan_out.addbus_drive <= add_drive;
            chan_out.rx_drive     <= rx_drive;
            chan_out.loop_active  <= loop_act;
            chan_out.ais_insert   <= ais_ins;
            chan_out.chan_reset   <= chan_rst;
            irq_out               <= irq_level;
            irq_oe                <= irq_drive;
            device_reset          <= seq_busy;
            test_sel              <= test_lbk_reg[TEST_HI_BIT:TEST_LO_BIT];
        end
    end

endmodule
`default_nettype wire

/* dv/common_ctrl_assertions.sv */
// port checker for the common device control block
`timescale 1ns/10ps
`default_nettype none
module common_ctrl_assertions
    import common_ctrl_pkg::*;
(
    input wire logic                        mclk,
    input wire logic                        srst,
    input wire logic [7:0]                  reg_addr,
    input wire logic                        reg_wr,
    input wire logic [7:0]                  reg_wdata,
    input wire logic [7:0]                  reg_rdata,
    input wire logic                        irq_oe,
    input wire common_ctrl_pkg::chan_ctrl_t chan_ctrl,
    input wire common_ctrl_pkg::chan_out_t  chan_out,
    input wire logic [1:0]                  test_sel,
    input wire logic                        device_reset
);
    // ======================================================
    // sequences
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_wr_c2;
        reg_wr && reg_addr == IRQ_OUT_EN_OFS;
    endsequence
    sequence s_rst_run;
        device_reset [*8] ##1 !device_reset;
    endsequence
    // ======================================================
    // properties
    chk_addbus_gate: assert property (
        (chan_out.addbus_drive & ~$past(chan_ctrl.addbus_en)) == 3'h0)
        else $error("add-bus driven without channel enable");
    chk_addbus_off: assert property (
        s_wr_c2 ##0 !reg_wdata[DEV_ADD_EN_BIT]
        |-> ##2 chan_out.addbus_drive == 3'h0)
        else $error("add-bus driven with device enable clear");
    chk_rx_gate: assert property (
        (chan_out.rx_drive & ~$past(chan_ctrl.rx_oe)) == 3'h0)
        else $error("receive outputs driven without channel enable");
    chk_rx_off: assert property (
        s_wr_c2 ##0 !reg_wdata[DEV_RX_OE_BIT]
        |-> ##2 chan_out.rx_drive == 3'h0)
        else $error("receive outputs driven with device enable clear");
    chk_ais_loop: assert property (
        (chan_out.ais_insert & ~chan_out.loop_active) == 3'h0)
        else $error("alarm inserted without loopback");
    chk_rst_hold: assert property (
        device_reset |-> chan_out.chan_reset == 3'h7 && !irq_oe
            && chan_out.addbus_drive == 3'h0)
        else $error("outputs not held during device reset");
    chk_rst_len: assert property (
        $rose(device_reset) |-> s_rst_run)
        else $error("device reset length wrong");
    chk_rst_clear: assert property (
        $fell(device_reset) |-> test_sel == 2'h0 && {chan_out.addbus_drive,
            chan_out.rx_drive, chan_out.chan_reset} == 9'h000)
        else $error("outputs not cleared after device reset");
    chk_hw_reset: assert property (
        $fell(srst) |-> !irq_oe && !device_reset && reg_rdata == 8'h00
            && {chan_out.addbus_drive, chan_out.rx_drive} == 6'h00)
        else $error("outputs not cleared by hardware reset");
endmodule
bind common_device_control common_ctrl_assertions i_common_ctrl_assertions (
    .mclk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .irq_oe,
    .chan_ctrl, .chan_out, .test_sel, .device_reset
);
`default_nettype wire

/* dv/common_device_control_tb.sv */
// self-checking bench for the common device control registers
`timescale 1ns/10ps
`default_nettype none
module common_device_control_tb;
    import common_ctrl_pkg::*;
    // ======================================================
    // design and stimulus
    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       motorola_mode = 1'b0;
    logic       irq_event = 1'b0;
    chan_ctrl_t chan_ctrl = '0;
    logic [7:0] reg_rdata;
    logic       irq_out;
    logic       irq_oe;
    chan_out_t  chan_out;
    logic [1:0] test_sel;
    logic       device_reset;
    int         n_errors = 0;
    int         checks = 0;
    always #25 mclk = ~mclk;
    common_device_control i_common_device_control (.mclk, .srst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .motorola_mode, .irq_event,
        .irq_out, .irq_oe, .chan_ctrl, .chan_out, .test_sel, .device_reset);
    // ======================================================
    // tasks
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        cmp({8'h00, reg_rdata}, {8'h00, e});
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ======================================================
    // tests
    initial begin
        tick(2);
        srst = 1'b0;
        rd(IRQ_OUT_EN_OFS, 8'h00);
        rd(RESET_CTRL_OFS, 8'h00);
        $display("test reset done");
        chan_ctrl = '{addbus_en: 3'h5, rx_oe: 3'h3, loopback: 3'h6};
        for (int d = 0; d < 4; d++) begin
            wr(IRQ_OUT_EN_OFS, 8'(d));
            tick(2);
            cmp({13'h0, chan_out.addbus_drive}, d[1] ? 16'h5 : 16'h0);
            cmp({13'h0, chan_out.rx_drive}, d[0] ? 16'h3 : 16'h0);
        end
        for (int d = 0; d < 2; d++) begin
            wr(TEST_LBK_OFS, 8'(d));
            tick(2);
            cmp({10'h0, chan_out.loop_active, chan_out.ais_insert},
                d[0] ? 16'h36 : 16'h30);
        end
        wr(TEST_LBK_OFS, 8'h06);
        tick(2);
        cmp({14'h0, test_sel}, 16'h3);
        wr(TEST_LBK_OFS, 8'h00);
        wr(RSVD_C3_OFS, 8'h00);
        rd(IRQ_OUT_EN_OFS, 8'h03);
        rd(RSVD_C3_OFS, 8'h00);
        $display("test gating done");
        for (int i = 0; i < 16; i++) begin
            motorola_mode = i[3];
            irq_event = i[0];
            wr(IRQ_OUT_EN_OFS, {4'h0, i[2:1], 2'h0});
            tick(4);
            cmp({14'h0, irq_oe, irq_out}, {14'h0, (i[0] & i[1]) |
                (i[2] & i[1]), (i[0] & i[1]) ^ i[3]});
        end
        $display("test interrupt done");
        wr(RESET_CTRL_OFS, 8'h0E);
        tick(2);
        cmp({13'h0, chan_out.chan_reset}, 16'h7);
        wr(RESET_CTRL_OFS, 8'h04);
        tick(12);
        cmp({13'h0, chan_out.chan_reset}, 16'h2);
        $display("test channel reset done");
        wr(IRQ_OUT_EN_OFS, 8'h03);
        wr(TEST_LBK_OFS, 8'h01);
        wr(RESET_CTRL_OFS, 8'h01);
        rd(RESET_CTRL_OFS, 8'h01);
        // ignored while the sequence runs
        wr(IRQ_OUT_EN_OFS, 8'h03);
        tick(10);
        cmp({15'h0, device_reset}, 16'h0);
        rd(IRQ_OUT_EN_OFS, 8'h00);
        rd(TEST_LBK_OFS, 8'h00);
        rd(RESET_CTRL_OFS, 8'h00);
        $display("test device reset done");
        // hardware reset with enables set and no sequence running
        wr(IRQ_OUT_EN_OFS, 8'h03);
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        rd(IRQ_OUT_EN_OFS, 8'h00);
        $display("test hardware reset done");
        report_and_stop();
    end
    initial begin
        repeat (2000) @(posedge mclk);
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
